// >>> src/e1tx_line_out.sv
// e1 transmit line output stage with transmit clock source selection
// assumes pins arrive asynchronously and config ports come from mclk
`timescale 1ns/100ps
`default_nettype none

module e1tx_line_out
    import e1tx_pkg::*;
#(
    parameter int PER_W = TX_PER_W,
    parameter int MULT_LOG2 = JAT_MULT_LOG2,
    parameter int DEPTH = BUF_DEPTH
)
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // asynchronous timing pins
    input wire logic tx_clock_in,
    input wire logic backplane_tx_clock,
    input wire logic recovered_rx_clock,
    // configuration
    input wire logic dual_rail_sel,
    input wire logic rz_format,
    input wire logic update_on_falling,
    input wire logic flag_sel_full,
    input wire logic jat_enable,
    input wire logic [1:0] clk_src_sel,
    input wire logic line_loopback,
    input wire logic analog_enable,
    // transmit data stream
    input wire logic in_valid,
    output logic in_ready,
    input wire logic in_pos,
    input wire logic in_neg,
    // line outputs
    output logic tx_clock_out,
    output logic tx_pos_pulse,
    output logic tx_neg_pulse,
    // status
    output logic tx_underrun,
    output logic tx_analog_lowpower
);

    logic rst_s1_r, rst_s2_r; // reset release synchroniser
    logic rst_core_n;
    logic [2:0] pin_vec;
    logic [2:0] s1_r, s2_r, s3_r;      // pin synchronisers and history
    logic [2:0] s1_nxt, s2_nxt, s3_nxt;
    logic [2:0] src_rise;
    e1tx_src_t eff_src;
    logic ref_edge;
    logic toggle;
    logic buf_valid, pop;
    logic [BUF_WIDTH-1:0] buf_data;
    logic [BUF_LVL_W-1:0] buf_level;
    logic near_flag, upd_evt, clr_evt;
    logic pos_r, pos_nxt;   // positive pulse or single rail data
    logic neg_r, neg_nxt;   // negative pulse or fifo flag
    logic und_r, und_nxt;
    logic lowp_r, lowp_nxt;

    // release reset only after two clean mclk edges
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_s1_r <= 1'h0;
            rst_s2_r <= 1'h0;
        end
        else
        begin
            rst_s1_r <= 1'h1;
            rst_s2_r <= rst_s1_r;
        end
    end
    assign rst_core_n = rst_s2_r;

    // clock pins sampled as data; third stage feeds the edge detect
    assign pin_vec = {recovered_rx_clock, backplane_tx_clock, tx_clock_in};
    always_comb
    begin
        s1_nxt = pin_vec;
        s2_nxt = s1_r;
        s3_nxt = s2_r;
    end

    always_ff @(posedge mclk or negedge rst_core_n)
    begin
        if (!rst_core_n)
        begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end
        else
        begin
            s1_r <= s1_nxt;
            s2_r <= s2_nxt;
            s3_r <= s3_nxt;
        end
    end

    // rising edges only from the second and third stages
    assign src_rise = s2_r & ~s3_r;

    // source choice; loopback overrides whatever software picked
    always_comb
    begin
        if (line_loopback)
        begin
            eff_src = SRC_RECOVERED;
        end
        else
        begin
            case (clk_src_sel)
                2'h1: eff_src = SRC_BACKPLANE;
                2'h2: eff_src = SRC_RECOVERED;
                default: eff_src = SRC_TXCLK;
            endcase
        end
        ref_edge = src_rise[eff_src];
    end

    // clock generator: the 2.048 MHz output comes from either mode
    e1tx_clkgen #(
        .PER_W(PER_W),
        .MULT_LOG2(MULT_LOG2)
    ) u_clkgen (
        .clk(mclk),
        .rst_n(rst_core_n),
        .ref_edge(ref_edge),
        .jat_enable(jat_enable),
        .clk_out(tx_clock_out),
        .toggle(toggle)
    );

    // rate conversion buffer; a stalled sender loses no word
    e1tx_buf #(
        .WIDTH(BUF_WIDTH),
        .DEPTH(DEPTH)
    ) u_buf (
        .clk(mclk),
        .rst_n(rst_core_n),
        .in_valid(in_valid),
        .in_ready(in_ready),
        .in_data({in_neg, in_pos}),
        .out_valid(buf_valid),
        .out_ready(pop),
        .out_data(buf_data),
        .level(buf_level)
    );

    // output stage: both line pins move on the same edge as the clock pin
    always_comb
    begin
        upd_evt = toggle & (update_on_falling ? tx_clock_out
                                              : ~tx_clock_out);
        clr_evt = toggle & ~upd_evt;
        near_flag = flag_sel_full ? (buf_level >= FLAG_FULL_MARK)
                                  : (buf_level <= FLAG_EMPTY_MARK);
        pos_nxt = pos_r;
        neg_nxt = neg_r;
        und_nxt = 1'h0;
        pop = 1'h0;
        if (upd_evt)
        begin
            pop = buf_valid;
            // an empty buffer sends spaces rather than stale data
            pos_nxt = buf_valid & buf_data[POS_BIT];
            und_nxt = ~buf_valid;
            if (dual_rail_sel)
            begin
                neg_nxt = buf_valid & buf_data[NEG_BIT];
            end
            else
            begin
                neg_nxt = near_flag;
            end
        end
        else if (clr_evt && dual_rail_sel && rz_format)
        begin
            // return to zero halfway through the bit
            pos_nxt = 1'h0;
            neg_nxt = 1'h0;
        end
        // analog driver follows software; reset leaves it powered down
        lowp_nxt = ~analog_enable;
    end

    always_ff @(posedge mclk or negedge rst_core_n)
    begin
        if (!rst_core_n)
        begin
            pos_r <= 1'h0;
            neg_r <= 1'h0;
            und_r <= 1'h0;
            lowp_r <= LOWPOWER_RESET;
        end
        else
        begin
            pos_r <= pos_nxt;
            neg_r <= neg_nxt;
            und_r <= und_nxt;
            lowp_r <= lowp_nxt;
        end
    end

    assign tx_pos_pulse = pos_r;
    assign tx_neg_pulse = neg_r;
    assign tx_underrun = und_r;
    assign tx_analog_lowpower = lowp_r;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_core_n);

    // dual rail word lands on both pins at the update edge
    property p_dual_word;
        (upd_evt && dual_rail_sel && buf_valid) |=>
            (tx_pos_pulse == $past(buf_data[POS_BIT]) &&
             tx_neg_pulse == $past(buf_data[NEG_BIT]));
    endproperty
    a_dual_word: assert property (p_dual_word)
        else $error("dual rail word not driven");

    // return to zero clears both pulses at the opposite edge
    property p_rz_clear;
        (clr_evt && dual_rail_sel && rz_format) |=>
            (!tx_pos_pulse && !tx_neg_pulse);
    endproperty
    a_rz_clear: assert property (p_rz_clear)
        else $error("rz pulse not cleared");

    // non return to zero holds over the opposite edge
    property p_nrz_hold;
        (clr_evt && dual_rail_sel && !rz_format) |=>
            ($stable(tx_pos_pulse) && $stable(tx_neg_pulse));
    endproperty
    a_nrz_hold: assert property (p_nrz_hold)
        else $error("nrz pulse changed mid bit");

    // line pins change only together with the clock pin
    property p_edge_aligned;
        ($changed(tx_pos_pulse) || $changed(tx_neg_pulse)) |->
            $changed(tx_clock_out);
    endproperty
    a_edge_aligned: assert property (p_edge_aligned)
        else $error("line output changed off a clock edge");

    // chosen edge polarity is the one the update lands on
    property p_edge_polarity;
        upd_evt |=> (tx_clock_out == !$past(update_on_falling));
    endproperty
    a_edge_polarity: assert property (p_edge_polarity)
        else $error("update on wrong clock edge");

    // single rail data pin carries the buffered bit
    property p_single_data;
        (upd_evt && !dual_rail_sel && buf_valid) |=>
            tx_pos_pulse == $past(buf_data[POS_BIT]);
    endproperty
    a_single_data: assert property (p_single_data)
        else $error("single rail data wrong");

    // flag pin reflects buffer level against the chosen mark
    property p_flag_level;
        (upd_evt && !dual_rail_sel) |=> tx_neg_pulse ==
            ($past(flag_sel_full) ? ($past(buf_level) >= FLAG_FULL_MARK)
                                  : ($past(buf_level) <= FLAG_EMPTY_MARK));
    endproperty
    a_flag_level: assert property (p_flag_level)
        else $error("fifo flag wrong");

    // backplane selection follows the backplane pin
    property p_backplane_src;
        (!line_loopback && clk_src_sel == 2'h1) |->
            ref_edge == src_rise[SRC_BACKPLANE];
    endproperty
    a_backplane_src: assert property (p_backplane_src)
        else $error("backplane clock not selected");

    // loopback always takes the recovered clock
    property p_loopback_src;
        line_loopback |-> ref_edge == src_rise[SRC_RECOVERED];
    endproperty
    a_loopback_src: assert property (p_loopback_src)
        else $error("loopback did not use recovered clock");

    // analog stays low power while not enabled
    property p_lowpower;
        !$past(analog_enable) |-> tx_analog_lowpower;
    endproperty
    a_lowpower: assert property (p_lowpower)
        else $error("analog driver left low power unasked");

    // main scenarios
    c_dual_rz: cover property (upd_evt && dual_rail_sel && rz_format
                               && buf_valid);
    c_single_flag: cover property (upd_evt && !dual_rail_sel && near_flag);
    c_loop_clock: cover property (line_loopback && toggle);
    c_underrun: cover property (tx_underrun);

endmodule : e1tx_line_out

`default_nettype wire

// >>> src/e1tx_pkg.sv
// constants and types shared by the e1 transmit line output stage
// assumes a single 20 MHz core clock; only the three timing pins and the reset release are synchronised inside
package e1tx_pkg;

    // core clock and nominal line clock rates in Hz
    localparam int CLK_HZ = 32'h0131_2D00;        // 20 MHz core clock
    localparam int NOMINAL_TX_HZ = 32'h001F_4000; // 2.048 MHz line clock
    localparam int CRYSTAL_JAT_HZ = 32'h02EE_0000;  // 49.152 MHz when attenuating
    localparam int CRYSTAL_PLAIN_HZ = 32'h00FA_0000; // 16.384 MHz otherwise

    // nominal output clock period in core cycles, rounded down
    localparam int NOM_PERIOD_CYC = CLK_HZ / NOMINAL_TX_HZ;

    // direct mode divides the selected reference by eight
    localparam int DIRECT_DIV = 32'h0000_0008;
    localparam int DIRECT_HALF_EDGES = DIRECT_DIV / 2;
    localparam int DIV_CNT_W = 2;
    localparam logic [DIV_CNT_W-1:0] DIV_LAST = 2'(DIRECT_HALF_EDGES - 1);

    // reference period tracker: wide enough for an 8 kHz reference
    localparam int TX_PER_W = 12;
    localparam int AVG_FRAC = 4;              // fraction bits of the average
    localparam int AVG_SHIFT = 3;             // loop gain of 1/8
    localparam int JAT_MULT_LOG2 = 0;         // ratio of one by default
    localparam logic [TX_PER_W+AVG_FRAC-1:0] AVG_RESET =
        16'(NOM_PERIOD_CYC << AVG_FRAC);
    localparam logic [TX_PER_W-1:0] MEAS_RESET = 12'h001;

    // rate conversion buffer and its level flag thresholds
    localparam int BUF_WIDTH = 2;
    localparam int BUF_DEPTH = 2;
    localparam int BUF_LVL_W = 2;
    localparam logic [BUF_LVL_W-1:0] FLAG_EMPTY_MARK = 2'h0;
    localparam logic [BUF_LVL_W-1:0] FLAG_FULL_MARK = 2'h2;

    // positions of the pulses inside a buffered word
    localparam int POS_BIT = 0;
    localparam int NEG_BIT = 1;

    // reset value of the analog low power state
    localparam logic LOWPOWER_RESET = 1'h1;

    // reference clock sources, also used as pin indices
    typedef enum logic [1:0] {
        SRC_TXCLK,
        SRC_BACKPLANE,
        SRC_RECOVERED
    } e1tx_src_t;

endpackage : e1tx_pkg

// >>> src/e1tx_buf.sv
// two entry buffer with valid and ready on both sides
// assumes one clock and an active low asynchronous reset
`timescale 1ns/100ps
`default_nettype none

module e1tx_buf
    import e1tx_pkg::*;
#(
    parameter int WIDTH = BUF_WIDTH,
    parameter int DEPTH = BUF_DEPTH
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    // occupancy
    output logic [$clog2(DEPTH+1)-1:0] level
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_r [DEPTH];   // storage words
    logic [WIDTH-1:0] mem_nxt [DEPTH];
    logic [PW-1:0] wr_ptr_r, wr_ptr_nxt;
    logic [PW-1:0] rd_ptr_r, rd_ptr_nxt;
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic push, pop;

    // full and empty come straight from the count, never guessed
    assign in_ready = (cnt_r != CW'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign out_data = mem_r[rd_ptr_r];
    assign level = cnt_r;

    // pointer, count and storage next values
    always_comb
    begin
        push = in_valid & in_ready;
        pop = out_valid & out_ready;
        mem_nxt = mem_r;
        wr_ptr_nxt = wr_ptr_r;
        rd_ptr_nxt = rd_ptr_r;
        cnt_nxt = cnt_r;
        if (push)
        begin
            mem_nxt[wr_ptr_r] = in_data;
            wr_ptr_nxt = (wr_ptr_r == PW'(DEPTH - 1)) ? '0 : wr_ptr_r + PW'(1);
        end
        if (pop)
        begin
            rd_ptr_nxt = (rd_ptr_r == PW'(DEPTH - 1)) ? '0 : rd_ptr_r + PW'(1);
        end
        // simultaneous push and pop leave the count alone
        if (push && !pop)
        begin
            cnt_nxt = cnt_r + CW'(1);
        end
        else if (pop && !push)
        begin
            cnt_nxt = cnt_r - CW'(1);
        end
    end

    // register stage
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < DEPTH; i++)
            begin
                mem_r[i] <= '0;
            end
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            cnt_r <= '0;
        end
        else
        begin
            mem_r <= mem_nxt;
            wr_ptr_r <= wr_ptr_nxt;
            rd_ptr_r <= rd_ptr_nxt;
            cnt_r <= cnt_nxt;
        end
    end

endmodule : e1tx_buf

`default_nettype wire

// >>> src/e1tx_clkgen.sv
// transmit clock generator: divide by eight or tracking attenuator
// assumes ref_edge is a one cycle pulse per rising reference edge
`timescale 1ns/100ps
`default_nettype none

module e1tx_clkgen
    import e1tx_pkg::*;
#(
    parameter int PER_W = TX_PER_W,
    parameter int MULT_LOG2 = JAT_MULT_LOG2
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // reference and mode
    input wire logic ref_edge,
    input wire logic jat_enable,
    // generated clock and its change strobe
    output logic clk_out,
    output logic toggle
);

    localparam int AVG_W = PER_W + AVG_FRAC;
    localparam int HALF_SH = AVG_FRAC + 1 + MULT_LOG2;

    logic [DIV_CNT_W-1:0] div_cnt_r, div_cnt_nxt; // reference edges seen
    logic [PER_W-1:0] meas_r, meas_nxt;           // cycles since last edge
    logic [AVG_W-1:0] avg_r, avg_nxt;             // smoothed period
    logic [AVG_W-1:0] gen_cnt_r, gen_cnt_nxt;     // half period counter
    logic clk_r, clk_nxt;
    logic [AVG_W-1:0] half_raw, half_cyc;
    logic signed [AVG_W:0] diff, step, sum;
    logic direct_tog, jat_tog;

    assign clk_out = clk_r;

    // both generators run all the time; the mode only picks the strobe
    always_comb
    begin
        div_cnt_nxt = div_cnt_r;
        direct_tog = 1'h0;
        if (ref_edge)
        begin
            if (div_cnt_r == DIV_LAST)
            begin
                div_cnt_nxt = '0;
                direct_tog = 1'h1;
            end
            else
            begin
                div_cnt_nxt = div_cnt_r + DIV_CNT_W'(1);
            end
        end
        // saturate so a slow 8 kHz reference never wraps the count
        if (ref_edge)
        begin
            meas_nxt = MEAS_RESET;
        end
        else if (meas_r == '1)
        begin
            meas_nxt = meas_r;
        end
        else
        begin
            meas_nxt = meas_r + PER_W'(1);
        end
        // first order loop: jitter is averaged out over about 8 edges
        diff = $signed({1'h0, meas_r, {AVG_FRAC{1'h0}}}) -
               $signed({1'h0, avg_r});
        step = diff >>> AVG_SHIFT;
        sum = $signed({1'h0, avg_r}) + step;
        avg_nxt = ref_edge ? sum[AVG_W-1:0] : avg_r;
        // half period scaled by the multiplication ratio, at least 1
        half_raw = avg_r >> HALF_SH;
        half_cyc = (half_raw == '0) ? AVG_W'(1) : half_raw;
        jat_tog = (gen_cnt_r >= half_cyc - AVG_W'(1));
        gen_cnt_nxt = jat_tog ? '0 : gen_cnt_r + AVG_W'(1);
        toggle = jat_enable ? jat_tog : direct_tog;
        clk_nxt = clk_r ^ toggle;
    end

    // register stage
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            div_cnt_r <= '0;
            meas_r <= MEAS_RESET;
            avg_r <= AVG_RESET;
            gen_cnt_r <= '0;
            clk_r <= 1'h0;
        end
        else
        begin
            div_cnt_r <= div_cnt_nxt;
            meas_r <= meas_nxt;
            avg_r <= avg_nxt;
            gen_cnt_r <= gen_cnt_nxt;
            clk_r <= clk_nxt;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // direct mode only changes the clock on a reference edge
    property p_div_on_edge;
        (!jat_enable && toggle) |-> ref_edge;
    endproperty
    a_div_on_edge: assert property (p_div_on_edge)
        else $error("direct clock changed without reference edge");

    // tracked clock half period is respected
    property p_jat_spacing;
        (jat_enable && toggle && half_cyc >= AVG_W'(2)) ##1 jat_enable
            |-> !toggle;
    endproperty
    a_jat_spacing: assert property (p_jat_spacing)
        else $error("tracked clock half period too short");

    // period measurement never wraps to zero
    property p_meas_nowrap;
        meas_r != '0;
    endproperty
    a_meas_nowrap: assert property (p_meas_nowrap)
        else $error("reference period count wrapped");

endmodule : e1tx_clkgen

`default_nettype wire

// >>> bench/e1tx_far_model.sv
// far side model: the three reference clocks feeding the stage
// assumes the bench itself watches the line pins
`timescale 1ns/100ps
`default_nettype none

module e1tx_far_model
#(
    parameter int TX_HALF = 250, // half periods in ns
    parameter int BP_HALF = 500,
    parameter int RX_HALF = 625
)
(
    // reference clocks towards the stage
    output logic tx_clock_in,
    output logic backplane_tx_clock,
    output logic recovered_rx_clock
);

    // each source runs free; odd offsets keep edges off mclk edges
    initial
    begin
        tx_clock_in = 1'b0;
        #13;
        forever #(TX_HALF) tx_clock_in = ~tx_clock_in;
    end

    // backplane clock, a different multiple of 8 kHz
    initial
    begin
        backplane_tx_clock = 1'b0;
        #7;
        forever #(BP_HALF) backplane_tx_clock = ~backplane_tx_clock;
    end

    // recovered receive clock, the slowest source
    initial
    begin
        recovered_rx_clock = 1'b0;
        #19;
        forever #(RX_HALF) recovered_rx_clock = ~recovered_rx_clock;
    end

endmodule : e1tx_far_model
`default_nettype wire

// >>> bench/tb.sv
// self-checking bench for the e1 transmit line output stage
// assumes the far model drives the reference pins freely
`timescale 1ns/100ps
`default_nettype none

module tb
    import e1tx_pkg::*;
;
    // reference half periods in ns: 250, 125 and 100 times 8 kHz
    localparam int HNS[5] = '{250, 500, 625, 625, 250};
    // clock, reset and configuration
    logic mclk, rst_n, dual, rz, fall, fsel, jat, lpbk, aen;
    logic [1:0] src;
    // stream and line side
    logic vld, rdy, ipos, ineg, tco, pos, neg, und, lowp;
    wire logic tci, bpc, rxc;
    int miscompares, n_compared, p, k;

    // far side clock sources
    e1tx_far_model far (.tx_clock_in(tci), .backplane_tx_clock(bpc),
        .recovered_rx_clock(rxc));

    e1tx_line_out DUT (.mclk(mclk), .rst_n(rst_n), .tx_clock_in(tci),
        .backplane_tx_clock(bpc), .recovered_rx_clock(rxc),
        .dual_rail_sel(dual), .rz_format(rz), .update_on_falling(fall),
        .flag_sel_full(fsel), .jat_enable(jat), .clk_src_sel(src),
        .line_loopback(lpbk), .analog_enable(aen), .in_valid(vld),
        .in_ready(rdy), .in_pos(ipos), .in_neg(ineg),
        .tx_clock_out(tco), .tx_pos_pulse(pos), .tx_neg_pulse(neg),
        .tx_underrun(und), .tx_analog_lowpower(lowp));

    // 20 MHz core clock; the board supplies it, one fixed rate for all modes
    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    // counts and reports one comparison
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check

    // the single place where the run ends
    task automatic test_done;
        $display("compares %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done

    // waits, bounded, until the clock output moves to lvl
    task automatic wait_tco(input logic lvl);
        int i;
        logic last;
        last = tco;
        for (i = 0; i < 400; i++)
        begin
            @(negedge mclk);
            if (tco !== last && tco === lvl)
                return;
            last = tco;
        end
        miscompares++;
        $display("wrong value at %0t: clock output stuck", $time);
        test_done();
    endtask : wait_tco

    // one full output clock period in core cycles
    task automatic period(output int c);
        time t0;
        wait_tco(1'b1);
        t0 = $time;
        wait_tco(1'b0);
        wait_tco(1'b1);
        c = int'(($time - t0) / 50);
    endtask : period

    // hands one word to the buffer, holding it while refused
    task automatic push(input logic [1:0] w);
        int i;
        @(negedge mclk);
        vld = 1'b1;
        {ineg, ipos} = w;
        for (i = 0; i < 400 && rdy !== 1'b1; i++)
            @(negedge mclk);
        if (i == 400)
        begin
            miscompares++;
            $display("wrong value at %0t: input word never accepted", $time);
            test_done();
        end
        @(negedge mclk);
        vld = 1'b0;
    endtask : push

    // next update edge, then the line pins as {pos, neg}
    task automatic see(input logic [1:0] exp);
        wait_tco(~fall);
        check(8'({pos, neg}), 8'(exp));
    endtask : see

    initial
    begin
        miscompares = 0;
        n_compared = 0;
        {rst_n, rz, fall, fsel, jat, lpbk, aen, vld, ipos, ineg} = '0;
        dual = 1'b1;
        src = 2'h0;
        repeat (16) @(negedge mclk);
        // reset state: all quiet, analog driver in low power
        check(8'({tco, pos, neg, und, lowp}), 8'h01);
        rst_n = 1'b1;
        repeat (4) @(negedge mclk);
        check(8'(lowp), 8'h01);
        aen = 1'b1;
        repeat (2) @(negedge mclk);
        check(8'(lowp), 8'h00);
        $display("test reset done");

        // every source; loopback overrides code 3, then code 3 alone
        for (k = 0; k < 5; k++)
        begin
            src = 2'((k == 4) ? 3 : k);
            lpbk = (k == 3);
            period(p);
            period(p);
            check(8'(p), 8'(DIRECT_DIV * HNS[k] / 25));
        end
        $display("test sources done");

        // attenuating generator, ratio one: tracks the reference
        {lpbk, src, jat} = 4'h1;
        repeat (60) period(p);
        check(8'(p >= 8 && p <= 11), 8'h01);
        jat = 1'b0;
        $display("test attenuator done");

        // dual rail nrz, then rz, on the rising edge
        period(p);
        push(2'h1);
        see(2'h2);
        push(2'h2);
        see(2'h1);
        rz = 1'b1;
        push(2'h1);
        see(2'h2);
        wait_tco(fall);
        check(8'({pos, neg}), 8'h00);
        // falling edge update: nothing moves on the rise
        {rz, fall} = 2'h1;
        push(2'h2);
        wait_tco(1'b1);
        check(8'({pos, neg}), 8'h00);
        see(2'h1);
        $display("test dual rail done");

        // single rail: empty update, then full buffer and drain
        {dual, fall} = 2'h0;
        see(2'h1);
        check(8'(und), 8'h01);
        fsel = 1'b1;
        push(2'h1);
        push(2'h0);
        check(8'(rdy), 8'h00);
        see(2'h3);
        see(2'h0);
        $display("test single rail done");
        test_done();
    end

endmodule : tb
`default_nettype wire
